// [rtl/acc_converter_ctrl.sv]
// converter control: ahb-lite registers, conversion sequencer, result presentation
`timescale 1ns/1ns
`default_nettype none
// How it works
// - a new channel or gain only applies to the next conversion
// - codes 0-7 pick single inputs, 30 bandgap, 31 ground
// - codes 8-15 differential with 10x/200x gain, 16-29 differential unity gain
// - enable bit powers up; clearing it aborts a running conversion
// - start write launches one conversion, or the first in free running
// - first conversion after enable takes 25 converter clocks, others 13
// - start bit reads one while converting; writing zero does nothing
// - auto-trigger starts a conversion on each rising trigger edge while idle
// - done flag sets when a conversion ends; result is stored unless locked
// - done flag clears on vector entry or when software writes one
// - interrupt request needs flag, local enable and global enable
// - prescale code divides system clock by 2,2,4,8,16,32,64,128
// - left adjust picks byte layout of the result; unused bits zero
// - differential results are stored in two's complement
// - reading low byte freezes the result until high byte is read
// - left adjust changes result presentation immediately
// - trigger select picks the source; ignored without auto-trigger
module acc_converter_ctrl #(
   parameter int N_TRIG = 7,
   parameter int PS_W   = 7
) (
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [9:0]        analog_result,
   input  wire logic [N_TRIG-1:0] trigger_sources,
   input  wire logic              global_int_enable,
   input  wire logic              vector_ack,
   output logic                   converter_power,
   output logic                   conv_busy,
   output logic [4:0]             channel_gain_select,
   output logic [1:0]             ref_select,
   output logic [1:0]             gain_select,
   output logic [1:0]             channel_class,
   output logic                   done_irq
);
   typedef enum logic {ST_IDLE, ST_CONV} acc_seq_t;

   typedef struct packed {
      acc_seq_t   seq;
      logic       busy;
      logic [7:0] cs;
      logic [7:0] insel;
      logic [2:0] trig_sel;
      logic [9:0] result;
      logic       lock;
      logic       first_pend;
      logic [4:0] cnt;
      logic [4:0] len;
      logic [4:0] act_chan;
      logic [1:0] act_ref;
      logic [1:0] gain;
      logic [1:0] cls;
      logic       wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] hrdata;
      logic       hreadyout;
      logic       irq;
   } acc_state_t;

   acc_state_t s_reg;
   acc_state_t s_next;
   logic       rst_meta_reg;
   logic       rst_n;
   logic       tick;
   logic       trig_fire;
   logic       take;
   logic       rd_fire;
   logic       rd_low;
   logic       rd_high;
   logic [5:0] idx;
   logic       sw_start;
   logic       start_now;
   logic       done_now;
   logic       free_run;
   logic       left;
   logic [7:0] rd_byte;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // converter clock enable
   acc_prescaler #(
      .CNT_W (PS_W)
   ) u_prescaler (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .run   (s_reg.cs[acc_pkg::CS_ENABLE]),
      .code  (s_reg.cs[acc_pkg::CS_PS_MSB:acc_pkg::CS_PS_LSB]),
      .tick  (tick)
   );

   // auto-trigger edge detection
   acc_trigger_edge #(
      .N_SRC (N_TRIG)
   ) u_trigger (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .arm     (s_reg.cs[acc_pkg::CS_AUTO]),
      .src_sel (s_reg.trig_sel),
      .sources (trigger_sources),
      .fire    (trig_fire)
   );

   // selector class: single, differential, bandgap or ground
   function automatic logic [1:0] chan_class(input logic [4:0] c);
      logic [1:0] r;
      r = acc_pkg::CLS_GROUND;
      if (c <= acc_pkg::CH_SE_LAST) begin
         r = acc_pkg::CLS_SINGLE;
      end else if (c <= acc_pkg::CH_DIFF_LAST) begin
         r = acc_pkg::CLS_DIFF;
      end else if (c == acc_pkg::CH_BANDGAP) begin
         r = acc_pkg::CLS_BANDGAP;
      end
      return r;
   endfunction

   // gain of a selector code
   function automatic logic [1:0] chan_gain(input logic [4:0] c);
      logic [1:0] g;
      g = acc_pkg::GAIN_1X;
      if (c > acc_pkg::CH_SE_LAST && c <= acc_pkg::CH_GAIN_LAST) begin
         g = c[acc_pkg::CH_HIGAIN_BIT] ? acc_pkg::GAIN_200X : acc_pkg::GAIN_10X;
      end
      return g;
   endfunction

   // next state: bus, register writes, sequencer, read data
   always_comb begin
      s_next    = s_reg;
      sw_start  = 1'b0;
      start_now = 1'b0;
      idx       = haddr[acc_pkg::ADDR_IDX_MSB:acc_pkg::ADDR_IDX_LSB];
      take      = hsel && (htrans == acc_pkg::HTRANS_NONSEQ) && hready;
      rd_fire   = take && !hwrite;
      rd_low    = rd_fire && (idx == acc_pkg::IDX_RESULT_LOW);
      rd_high   = rd_fire && (idx == acc_pkg::IDX_RESULT_HIGH);
      free_run  = s_reg.cs[acc_pkg::CS_AUTO] && (s_reg.trig_sel == acc_pkg::FREE_RUN_SRC);
      done_now  = (s_reg.seq == ST_CONV) && tick && (s_reg.cnt == 5'(s_reg.len - 5'h01));
      s_next.wr_pend   = take && hwrite;
      s_next.wr_idx    = idx;
      s_next.hreadyout = 1'b1;

      // register writes land in the data phase
      if (s_reg.wr_pend) begin
         case (s_reg.wr_idx)
            acc_pkg::IDX_CTRL_STATUS: begin
               s_next.cs[acc_pkg::CS_ENABLE] = hwdata[acc_pkg::CS_ENABLE];
               s_next.cs[acc_pkg::CS_AUTO]   = hwdata[acc_pkg::CS_AUTO];
               s_next.cs[acc_pkg::CS_IE]     = hwdata[acc_pkg::CS_IE];
               s_next.cs[acc_pkg::CS_PS_MSB:acc_pkg::CS_PS_LSB] =
                  hwdata[acc_pkg::CS_PS_MSB:acc_pkg::CS_PS_LSB];
               if (hwdata[acc_pkg::CS_FLAG]) begin
                  s_next.cs[acc_pkg::CS_FLAG] = 1'b0;
               end
               sw_start = hwdata[acc_pkg::CS_START];
            end
            acc_pkg::IDX_INPUT_SELECT: begin
               s_next.insel = hwdata[7:0];
            end
            acc_pkg::IDX_TRIGGER_CFG: begin
               s_next.trig_sel = hwdata[acc_pkg::TC_SRC_MSB:0];
            end
            default: begin
            end
         endcase
      end

      // enabling arms the long initialising conversion
      if (!s_reg.cs[acc_pkg::CS_ENABLE] && s_next.cs[acc_pkg::CS_ENABLE]) begin
         s_next.first_pend = 1'b1;
      end
      if (vector_ack) begin
         s_next.cs[acc_pkg::CS_FLAG] = 1'b0;
      end

      // conversion sequencer, counting converter clock ticks
      case (s_reg.seq)
         ST_IDLE: begin
            start_now = s_next.cs[acc_pkg::CS_ENABLE] &&
                        (sw_start || (s_reg.cs[acc_pkg::CS_AUTO] && trig_fire));
         end
         ST_CONV: begin
            if (tick) begin
               s_next.cnt = 5'(s_reg.cnt + 5'h01);
            end
            if (done_now) begin
               s_next.seq = ST_IDLE;
               s_next.cs[acc_pkg::CS_FLAG] = 1'b1;
               if (!s_reg.lock) begin
                  s_next.result = analog_result;
                  if (s_reg.cls == acc_pkg::CLS_DIFF) begin
                     s_next.result[acc_pkg::RESULT_MSB] = ~analog_result[acc_pkg::RESULT_MSB];
                  end
               end
               start_now = free_run && s_next.cs[acc_pkg::CS_ENABLE];
            end
         end
         default: begin
            s_next.seq = ST_IDLE;
         end
      endcase

      // a start latches the selection for the whole conversion
      if (start_now) begin
         s_next.seq        = ST_CONV;
         s_next.cnt        = '0;
         s_next.len        = s_next.first_pend ? acc_pkg::CONV_FIRST_CYCLES
                                               : acc_pkg::CONV_NORMAL_CYCLES;
         s_next.first_pend = 1'b0;
         s_next.act_chan   = s_next.insel[acc_pkg::IS_CHAN_MSB:acc_pkg::IS_CHAN_LSB];
         s_next.act_ref    = s_next.insel[acc_pkg::IS_REF_MSB:acc_pkg::IS_REF_LSB];
         s_next.gain       = chan_gain(s_next.act_chan);
         s_next.cls        = chan_class(s_next.act_chan);
      end

      // turning the converter off aborts
      if (!s_next.cs[acc_pkg::CS_ENABLE]) begin
         s_next.seq = ST_IDLE;
         s_next.cnt = '0;
      end
      s_next.busy = (s_next.seq == ST_CONV);

      // result read lock
      if (rd_low) begin
         s_next.lock = 1'b1;
      end
      if (rd_high) begin
         s_next.lock = 1'b0;
      end

      // interrupt request gating
      s_next.irq = s_reg.cs[acc_pkg::CS_FLAG] && s_reg.cs[acc_pkg::CS_IE] && global_int_enable;

      // read data from post-write state, current left adjust
      left = s_next.insel[acc_pkg::IS_LEFT];
      case (idx)
         acc_pkg::IDX_RESULT_LOW: begin
            rd_byte = left ? {s_next.result[1:0], 6'h00} : s_next.result[7:0];
         end
         acc_pkg::IDX_RESULT_HIGH: begin
            rd_byte = left ? s_next.result[9:2] : {6'h00, s_next.result[9:8]};
         end
         acc_pkg::IDX_CTRL_STATUS: begin
            rd_byte = s_next.cs;
            rd_byte[acc_pkg::CS_START] = s_next.busy;
         end
         acc_pkg::IDX_INPUT_SELECT: begin
            rd_byte = s_next.insel;
         end
         acc_pkg::IDX_TRIGGER_CFG: begin
            rd_byte = {5'h00, s_next.trig_sel};
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
      s_next.hrdata = rd_fire ? {24'h000000, rd_byte} : 32'h00000000;
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg           <= '0;
         s_reg.seq       <= ST_IDLE;
         s_reg.cs        <= acc_pkg::CTRL_RESET;
         s_reg.insel     <= acc_pkg::INSEL_RESET;
         s_reg.trig_sel  <= acc_pkg::TRIG_RESET;
         s_reg.result    <= acc_pkg::RESULT_RESET;
         s_reg.hreadyout <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register, except hresp tied to okay
   assign hrdata              = s_reg.hrdata;
   assign hreadyout           = s_reg.hreadyout;
   assign hresp               = acc_pkg::HRESP_OKAY;
   assign converter_power     = s_reg.cs[acc_pkg::CS_ENABLE];
   assign conv_busy           = s_reg.busy;
   assign channel_gain_select = s_reg.act_chan;
   assign ref_select          = s_reg.act_ref;
   assign gain_select         = s_reg.gain;
   assign channel_class       = s_reg.cls;
   assign done_irq            = s_reg.irq;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_chan_held_busy: assert property (
      (s_reg.busy && $past(s_reg.busy) && !$past(done_now)) |-> $stable(s_reg.act_chan) && $stable(s_reg.act_ref))
      else $error("channel changed during conversion");
   a_diff_class: assert property (
      $rose(s_reg.busy) |-> (s_reg.cls == acc_pkg::CLS_DIFF) ==
         (s_reg.act_chan > acc_pkg::CH_SE_LAST && s_reg.act_chan <= acc_pkg::CH_DIFF_LAST))
      else $error("differential class wrong");
   a_off_aborts: assert property (
      !s_reg.cs[acc_pkg::CS_ENABLE] |-> !s_reg.busy)
      else $error("converter busy while off");
   a_first_length: assert property (
      $rose(s_reg.busy) |-> s_reg.len == ($past(s_reg.first_pend) || !$past(s_reg.cs[acc_pkg::CS_ENABLE])
         ? acc_pkg::CONV_FIRST_CYCLES : acc_pkg::CONV_NORMAL_CYCLES))
      else $error("conversion length wrong");
   a_start_reads: assert property (
      (rd_fire && idx == acc_pkg::IDX_CTRL_STATUS && !s_reg.wr_pend) |=>
         s_reg.hrdata[acc_pkg::CS_START] == s_reg.busy)
      else $error("start bit read mismatch");
   a_done_sets_flag: assert property (
      done_now |=> s_reg.cs[acc_pkg::CS_FLAG])
      else $error("done flag not set");
   a_ack_clears: assert property (
      (vector_ack && !done_now) |=> !s_reg.cs[acc_pkg::CS_FLAG])
      else $error("flag not cleared by vector");
   a_irq_gated: assert property (
      s_reg.irq |-> $past(s_reg.cs[acc_pkg::CS_FLAG] && s_reg.cs[acc_pkg::CS_IE] && global_int_enable))
      else $error("interrupt without all enables");
   a_lock_holds: assert property (
      (s_reg.lock && !rd_high) |=> $stable(s_reg.result))
      else $error("result changed while locked");
   a_twos_compl: assert property (
      (done_now && !s_reg.lock && s_reg.cls == acc_pkg::CLS_DIFF) |=>
         s_reg.result[acc_pkg::RESULT_MSB] == !$past(analog_result[acc_pkg::RESULT_MSB]))
      else $error("differential sign not flipped");
   a_free_restart: assert property (
      (done_now && free_run && s_reg.cs[acc_pkg::CS_ENABLE] && !(s_reg.wr_pend &&
         s_reg.wr_idx == acc_pkg::IDX_CTRL_STATUS)) |=> s_reg.busy)
      else $error("free running did not restart");
endmodule
`default_nettype wire

// [shared/acc_pkg.sv]
// constants for the analog converter control block
package acc_pkg;
   // register word indexes; byte address is four times the index
   localparam logic [5:0] IDX_RESULT_LOW   = 6'h04;
   localparam logic [5:0] IDX_RESULT_HIGH  = 6'h05;
   localparam logic [5:0] IDX_CTRL_STATUS  = 6'h06;
   localparam logic [5:0] IDX_INPUT_SELECT = 6'h07;
   localparam logic [5:0] IDX_TRIGGER_CFG  = 6'h08;
   localparam int         ADDR_IDX_LSB     = 2;
   localparam int         ADDR_IDX_MSB     = 7;

   // reset values
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] INSEL_RESET = 8'h00;
   localparam logic [2:0] TRIG_RESET  = 3'h0;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   // converter_control_status fields
   localparam int CS_ENABLE = 7;
   localparam int CS_START  = 6;
   localparam int CS_AUTO   = 5;
   localparam int CS_FLAG   = 4;
   localparam int CS_IE     = 3;
   localparam int CS_PS_MSB = 2;
   localparam int CS_PS_LSB = 0;

   // input_select_register fields
   localparam int IS_REF_MSB  = 7;
   localparam int IS_REF_LSB  = 6;
   localparam int IS_LEFT     = 5;
   localparam int IS_CHAN_MSB = 4;
   localparam int IS_CHAN_LSB = 0;

   // trigger_config_register field
   localparam int TC_SRC_MSB = 2;
   localparam logic [2:0] FREE_RUN_SRC = 3'h0;

   // conversion lengths in converter clock cycles
   localparam int         CONV_CNT_W         = 5;
   localparam logic [4:0] CONV_FIRST_CYCLES  = 5'h19;
   localparam logic [4:0] CONV_NORMAL_CYCLES = 5'h0d;

   // prescaler: codes at or below this divide by two
   localparam logic [2:0] PS_MIN_CODE = 3'h1;

   // channel selector decode
   localparam logic [4:0] CH_SE_LAST    = 5'h07;
   localparam logic [4:0] CH_GAIN_LAST  = 5'h0f;
   localparam logic [4:0] CH_DIFF_LAST  = 5'h1d;
   localparam logic [4:0] CH_BANDGAP    = 5'h1e;
   localparam int         CH_HIGAIN_BIT = 1;
   localparam logic [1:0] CLS_SINGLE  = 2'h0;
   localparam logic [1:0] CLS_DIFF    = 2'h1;
   localparam logic [1:0] CLS_BANDGAP = 2'h2;
   localparam logic [1:0] CLS_GROUND  = 2'h3;
   localparam logic [1:0] GAIN_1X     = 2'h0;
   localparam logic [1:0] GAIN_10X    = 2'h1;
   localparam logic [1:0] GAIN_200X   = 2'h2;

   // result layout
   localparam int RESULT_W   = 10;
   localparam int RESULT_MSB = 9;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// [rtl/acc_prescaler.sv]
// converter clock prescaler producing a one-cycle tick enable
`timescale 1ns/1ns
`default_nettype none
module acc_prescaler #(
   parameter int CNT_W = 7
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [2:0] code,
   output logic            tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } acc_ps_state_t;

   acc_ps_state_t    s_reg;
   acc_ps_state_t    s_next;
   logic [2:0]       eff_code;
   logic [CNT_W:0]   full;
   logic [CNT_W-1:0] mask;

   // divide by two to the code, codes 0 and 1 both give two
   always_comb begin
      eff_code = (code <= acc_pkg::PS_MIN_CODE) ? acc_pkg::PS_MIN_CODE : code;
      full = ((CNT_W+1)'(1) << eff_code) - (CNT_W+1)'(1);
      mask = full[CNT_W-1:0];
      s_next = s_reg;
      s_next.cnt = run ? CNT_W'(s_reg.cnt + 1'b1) : '0;
      s_next.tick = run && ((s_reg.cnt & mask) == mask);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule
`default_nettype wire

// [rtl/acc_trigger_edge.sv]
// auto-trigger source select and rising edge detector
`timescale 1ns/1ns
`default_nettype none
module acc_trigger_edge #(
   parameter int N_SRC = 7
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             arm,
   input  wire logic [2:0]       src_sel,
   input  wire logic [N_SRC-1:0] sources,
   output logic                  fire
);
   typedef struct packed {
      logic prev;
      logic fire;
   } acc_tr_state_t;

   acc_tr_state_t s_reg;
   acc_tr_state_t s_next;
   logic          level;

   // free running has no trigger line, so switching to it makes no edge
   always_comb begin
      level = 1'b0;
      if (src_sel != acc_pkg::FREE_RUN_SRC) begin
         level = sources[3'(src_sel - 3'h1)];
      end
      s_next.prev = level;
      s_next.fire = arm && level && !s_reg.prev;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign fire = s_reg.fire;
endmodule
`default_nettype wire

// [dv/acc_front_model.sv]
// far-side model: analog front end code source and processor vector entry
`timescale 1ns/1ns
`default_nettype none
module acc_front_model (
   input  wire logic       ref_clk,
   input  wire logic [4:0] channel_gain_select,
   input  wire logic       done_irq,
   input  wire logic       ack_en,
   output logic [9:0]      analog_result,
   output logic            vector_ack = 1'b0
);
   // raw offset-binary code that names the selected channel
   assign analog_result = {channel_gain_select, 5'h0b};

   // processor enters the vector one cycle after a request, one-cycle pulses on alternate cycles while it is high
   always @(posedge ref_clk) begin
      vector_ack <= ack_en & done_irq & ~vector_ack;
   end
endmodule
`default_nettype wire

// [dv/acc_converter_ctrl_tb_top.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_converter_ctrl_tb_top;
   localparam logic [7:0] A_LO = {acc_pkg::IDX_RESULT_LOW, 2'b00};
   localparam logic [7:0] A_HI = {acc_pkg::IDX_RESULT_HIGH, 2'b00};
   localparam logic [7:0] A_CS = {acc_pkg::IDX_CTRL_STATUS, 2'b00};
   localparam logic [7:0] A_IS = {acc_pkg::IDX_INPUT_SELECT, 2'b00};
   localparam logic [7:0] A_TC = {acc_pkg::IDX_TRIGGER_CFG, 2'b00};
   logic        ref_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic [6:0]  trig    = 7'h0;
   logic        gie     = 1'b0;
   logic        ack_en  = 1'b0;
   logic [31:0] hrdata, rd_q;
   logic        hreadyout, rdy_q, hresp, vector_ack, power, conv_busy, done_irq;
   logic [9:0]  analog_result;
   logic [4:0]  chan;
   logic [1:0]  gain_select, channel_class, rsel;
   logic [7:0]  r;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   int          run_len    = 0;
   int          last_len   = 0;

   acc_converter_ctrl acc_converter_ctrl_i (
      .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .analog_result(analog_result),
      .trigger_sources(trig), .global_int_enable(gie), .vector_ack(vector_ack),
      .converter_power(power), .conv_busy(conv_busy), .channel_gain_select(chan),
      .ref_select(rsel), .gain_select(gain_select), .channel_class(channel_class),
      .done_irq(done_irq));
   acc_front_model acc_front_model_i (
      .ref_clk(ref_clk), .channel_gain_select(chan), .done_irq(done_irq),
      .ack_en(ack_en), .analog_result(analog_result), .vector_ack(vector_ack));

   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;

   // edge samples of bus answers and length of each busy run
   always @(posedge ref_clk) begin
      rd_q <= hrdata;
      rdy_q <= hreadyout;
      run_len <= conv_busy ? run_len + 1 : 0;
      if (!conv_busy && run_len != 0) last_len <= run_len;
   end

   task automatic step(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic cmp(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_len(input int lo, hi);
      n_tests++;
      if (last_len < lo || last_len > hi) begin
         n_mismatch++;
         $display("BAD t=%0t len=%h range=%h..%h", $time, last_len, lo, hi);
      end
   endtask

   // one single ahb-lite transfer; read byte lands in r
   task automatic bus(input logic w, input logic [7:0] a, d);
      hsel <= 1'b1;
      htrans <= acc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do step(); while (rdy_q !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do step(); while (rdy_q !== 1'b1);
      r = rd_q[7:0];
   endtask

   task automatic chk(input logic [7:0] a, e);
      bus(1'b0, a, 8'h00);
      cmp({24'h0, r}, {24'h0, e});
   endtask

   task automatic wait_done;
      int k;
      k = 0;
      step(2);
      while (conv_busy !== 1'b0 && k < 4000) begin
         step();
         k++;
      end
      // a conversion that never ends counts as a mismatch
      if (conv_busy !== 1'b0) n_mismatch++;
      // one more edge so the run length sampler has stored the finished run
      step();
   endtask

   // expected {high, low} bytes for a channel code from the model
   function automatic logic [15:0] res(input logic [4:0] ch, input logic left);
      logic [9:0] v;
      v = {ch, 5'h0b};
      if (ch > 5'h07 && ch < 5'h1e) v[9] = ~v[9];
      return left ? {v[9:2], v[1:0], 6'h00} : {6'h00, v};
   endfunction

   task automatic chk_res(input logic [4:0] ch, input logic left);
      logic [15:0] e;
      e = res(ch, left);
      chk(A_LO, e[7:0]);
      chk(A_HI, e[15:8]);
   endtask

   task automatic t_reset;
      chk(A_LO, 8'h00);
      chk(A_HI, 8'h00);
      chk(A_CS, 8'h00);
      bus(1'b1, 8'h40, 8'hff);
      chk(8'h40, 8'h00);
      cmp({31'h0, hresp}, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_first;
      bus(1'b1, A_IS, 8'h03);
      bus(1'b1, A_CS, 8'hc0);
      chk(A_CS, 8'hc0);
      bus(1'b1, A_CS, 8'h80);
      cmp({31'h0, conv_busy}, 32'h1);
      wait_done;
      cmp_len(48, 51);
      chk(A_CS, 8'h90);
      chk_res(5'h03, 1'b0);
      step(30);
      cmp({31'h0, conv_busy}, 32'h0);
      bus(1'b1, A_CS, 8'h90);
      chk(A_CS, 8'h80);
      $display("test first conversion done");
   endtask

   task automatic t_prescale;
      int d;
      for (int p = 0; p < 8; p++) begin
         bus(1'b1, A_CS, 8'h80 | p[7:0]); // new divide settles before the start
         bus(1'b1, A_CS, 8'hc0 | p[7:0]);
         wait_done;
         d = (p < 2) ? 2 : (1 << p);
         cmp_len(12 * d, 13 * d + 1);
      end
      $display("test prescaler done");
   endtask

   task automatic t_select;
      logic [4:0] ch;
      logic [1:0] cl, g;
      for (int c = 0; c < 32; c++) begin
         ch = c[4:0];
         bus(1'b1, A_IS, {3'h0, ch});
         bus(1'b1, A_CS, 8'hc0);
         wait_done;
         cl = ch < 5'h08 ? 2'h0 : ch < 5'h1e ? 2'h1 : ch == 5'h1e ? 2'h2 : 2'h3;
         g = (ch < 5'h08 || ch > 5'h0f) ? 2'h0 : ch[1] ? 2'h2 : 2'h1;
         cmp({23'h0, chan, channel_class, gain_select}, {23'h0, ch, cl, g});
         chk_res(ch, 1'b0);
      end
      $display("test channel select done");
   endtask

   task automatic t_adjust_lock;
      bus(1'b1, A_IS, 8'h08);
      bus(1'b1, A_CS, 8'hc0);
      bus(1'b1, A_IS, 8'hef);
      cmp({25'h0, rsel, chan}, 32'h8);
      wait_done;
      chk_res(5'h08, 1'b1);
      bus(1'b1, A_IS, 8'h0f);
      chk_res(5'h08, 1'b0);
      bus(1'b1, A_IS, 8'he3);
      bus(1'b1, A_CS, 8'hc0);
      wait_done;
      cmp({25'h0, rsel, chan}, 32'h63);
      chk(A_LO, 8'hc0);
      bus(1'b1, A_IS, 8'h25);
      bus(1'b1, A_CS, 8'hc0);
      wait_done;
      chk(A_HI, 8'h1a);
      bus(1'b1, A_CS, 8'hc0);
      wait_done;
      chk_res(5'h05, 1'b1);
      $display("test adjust and lock done");
   endtask

   task automatic t_irq;
      bus(1'b1, A_CS, 8'h98);
      bus(1'b1, A_CS, 8'hc8);
      wait_done;
      step(2);
      cmp({31'h0, done_irq}, 32'h0);
      gie <= 1'b1;
      step(2);
      cmp({31'h0, done_irq}, 32'h1);
      bus(1'b1, A_CS, 8'h80);
      step();
      cmp({31'h0, done_irq}, 32'h0);
      bus(1'b1, A_CS, 8'h88);
      ack_en <= 1'b1;
      step(6);
      ack_en <= 1'b0;
      cmp({31'h0, done_irq}, 32'h0);
      chk(A_CS, 8'h88);
      $display("test interrupt done");
   endtask

   task automatic t_abort;
      bus(1'b1, A_CS, 8'hc0);
      step(4);
      bus(1'b1, A_CS, 8'h00);
      step();
      cmp({30'h0, power, conv_busy}, 32'h0);
      chk(A_CS, 8'h00);
      bus(1'b1, A_CS, 8'hc0);
      wait_done;
      cmp_len(48, 51);
      $display("test abort done");
   endtask

   task automatic t_auto;
      bus(1'b1, A_TC, 8'h02);
      trig <= 7'h02;
      step(4);
      cmp({31'h0, conv_busy}, 32'h0);
      trig <= 7'h00;
      bus(1'b1, A_CS, 8'ha0);
      trig <= 7'h02;
      step(3);
      cmp({31'h0, conv_busy}, 32'h1);
      wait_done;
      step(20);
      cmp({31'h0, conv_busy}, 32'h0);
      trig <= 7'h00;
      bus(1'b1, A_TC, 8'h00);
      bus(1'b1, A_CS, 8'he0);
      step(60);
      chk(A_CS, 8'hf0);
      bus(1'b1, A_CS, 8'h90);
      wait_done;
      $display("test auto trigger done");
   endtask

   task automatic final_report;
      $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // main sequence after a three-cycle reset
   initial begin
      step(3);
      rstn <= 1'b1;
      step(3);
      t_reset;
      t_first;
      t_prescale;
      t_select;
      t_adjust_lock;
      t_irq;
      t_abort;
      t_auto;
      final_report;
   end

   // watchdog: the tests need about 5000 cycles, this allows 25000
   initial begin
      #500000;
      n_mismatch++;
      final_report;
   end
endmodule
`default_nettype wire
